// File: rtl/cso_map.svh
// Constants for the conversion sequencer and its observation port.
// Assumes one 125 MHz clock; every count here is in clock cycles.
`ifndef CSO_MAP_SVH
`define CSO_MAP_SVH

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define CSO_ADC_CYCLES   130585      // Digitizing phase length
`define CSO_SLOT_CYCLES  16          // Clocks per microcode instruction
`define CSO_FIRST_OBS    9           // Clocks from phase start to first slot
`define CSO_EOC_CYCLES   8           // End-of-conversion pulse width

// ----------------------------------------------------------------
// Microcode program layout
// ----------------------------------------------------------------
`define CSO_LAST_PTR     8'hC9       // 202 instructions, 3241 clocks
`define CSO_CODE_FINAL   8'hD0       // Final instruction code
`define CSO_CODE_RESULT  8'hEA       // Compensated output instruction
`define CSO_CODE_NOP     8'h00       // Plain arithmetic step

// ----------------------------------------------------------------
// Start command codes
// ----------------------------------------------------------------
`define CSO_CMD_OBS_HOLD 4'h8        // Observe, keep registers
`define CSO_CMD_OBS_LOAD 4'hA        // Observe, reload coefficients
`define CSO_CMD_QUI_HOLD 4'hC        // Silent, keep registers
`define CSO_CMD_QUI_LOAD 4'hE        // Silent, reload coefficients

// ----------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------
`define CSO_CFG_AMP_ON   7           // Amplifier enabled when set
`define CSO_CFG_REPEAT   15          // Repeat mode

`endif

// File: rtl/cso_pkg.sv
// Types shared by the conversion sequencer files.
// Assumes cso_map.svh supplies the numeric constants.
package cso_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSO_IDLE,
    CSO_ADC,
    CSO_LEAD,
    CSO_DSP,
    CSO_EOC
  } cso_state_t;

  typedef logic [15:0] cso_word_t;  // Scratch and configuration width
  typedef logic [7:0]  cso_byte_t;  // Pointer and program store width

endpackage

// File: rtl/cso_obs_shifter.sv
// Serial shifter for the observation lines.
// Assumes load is a one-cycle pulse from the sequencer on the same clock.
`timescale 1ns/10ps
`include "cso_map.svh"

module cso_obs_shifter (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire cso_pkg::cso_word_t scratch,
  input  wire cso_pkg::cso_byte_t pointer,
  input  wire cso_pkg::cso_byte_t program_store,
  output logic                  data_bit,
  output logic                  status_bit,
  output logic                  busy
);
  import cso_pkg::*;

  cso_word_t   data_reg,   data_next;    // Scratch frame
  cso_word_t   stat_reg,   stat_next;    // Pointer and store frame
  logic [4:0]  left_reg,   left_next;    // Bits still to send

  // ----------------------------------------------------------------
  // Shift next-state
  // ----------------------------------------------------------------
  // MSB first so the LSB is the last bit of each frame
  always_comb begin
    data_next = data_reg;
    stat_next = stat_reg;
    left_next = left_reg;
    if (load) begin
      data_next = scratch;
      stat_next = {program_store, pointer};
      left_next = 5'd16;
    end else if (left_reg != 5'd0) begin
      data_next = {data_reg[14:0], 1'b0};
      stat_next = {stat_reg[14:0], 1'b0};
      left_next = left_reg - 5'd1;
    end
  end

  // Registers only
  always_ff @(posedge clock) begin
    if (rst) begin
      data_reg <= 16'h0000;
      stat_reg <= 16'h0000;
      left_reg <= 5'd0;
    end else begin
      data_reg <= data_next;
      stat_reg <= stat_next;
      left_reg <= left_next;
    end
  end

  // Idle lines rest low between frames
  assign data_bit   = (left_reg != 5'd0) ? data_reg[15] : 1'b0;
  assign status_bit = (left_reg != 5'd0) ? stat_reg[15] : 1'b0;
  assign busy       = (left_reg != 5'd0);

  // A load always opens a full 16-bit frame
  frame_len_a: assert property (@(posedge clock) disable iff (rst)
    load |=> busy [*8] ##1 busy [*8] ##1 (!busy || $past(load)))
    else $error("observation frame is not 16 bits long");

endmodule

// File: rtl/cso_sequencer.sv
// Conversion sequencer with microcode observation port.
// Assumes the datapath presents the executed instruction's result on
// scratch_in, and that a decoder pulses cmd_valid for start commands.
//
// Functional notes
// - Scratch result shown on observation port
// - Program pointer shown on observation port
// - Program store equals ROM at pointer
// - Observing start drives both serial lines
// - Shift registers out after each instruction
// - New instruction every sixteen clocks, offset nine
// - Start on edge, command, or repeat
// - Fixed digitizing phase, then microcode phase
// - First frame after digitizing; last code final
// - Release status line while reset low
// - End pulse eight clocks; host latches
// - Temperature digitized in first half
// - Start tied high converts after power
// - Result becomes bitstream on output pin
// - Amplifier power follows configuration bit
// - Silent commands; load commands reload coefficients
// - End of the end pulse tests repeat bit
`timescale 1ns/10ps
`include "cso_map.svh"

module cso_sequencer #(
  parameter int unsigned ADC_CYCLES = `CSO_ADC_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               start_pin,
  input  wire logic               tester_reset_n_pin,
  input  wire logic               test_mode_pin,
  input  wire logic               cmd_valid,
  input  wire logic [3:0]         cmd_code,
  input  wire cso_pkg::cso_word_t cfg_word,
  input  wire cso_pkg::cso_word_t scratch_in,
  input  wire logic               sdio_in,
  output logic                    sdio_out,
  output logic                    sdio_oe,
  output logic                    serial_observe_out,
  output logic                    serial_observe_oe,
  output cso_pkg::cso_byte_t      program_pointer,
  output cso_pkg::cso_byte_t      program_store,
  output logic                    coef_reload,
  output logic                    adc_temp_phase,
  output logic                    adc_busy,
  output logic [11:0]             result,
  output logic                    eoc,
  output logic                    dac_out,
  output logic                    amp_enable
);
  import cso_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_raw;           // start, tester reset, test mode
  logic [NPIN-1:0] pin_s1;            // First stage, read by s2 only
  logic [NPIN-1:0] pin_s2;            // Second stage
  logic [NPIN-1:0] pin_s3;            // Third stage
  logic [NPIN-1:0] pin_lvl_reg;       // Accepted level
  logic [NPIN-1:0] pin_lvl_next;

  assign pin_raw = {test_mode_pin, tester_reset_n_pin, start_pin};

  // A change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      always_comb begin
        pin_lvl_next[gi] = pin_lvl_reg[gi];
        if (pin_s2[gi] == pin_s3[gi]) begin
          pin_lvl_next[gi] = pin_s3[gi];
        end
      end
    end
  endgenerate

  // Stages; start level resets low so a tied-high pin reads as an edge
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1      <= 3'b000;
      pin_s2      <= 3'b000;
      pin_s3      <= 3'b000;
      pin_lvl_reg <= 3'b000;
    end else begin
      pin_s1      <= pin_raw;
      pin_s2      <= pin_s1;
      pin_s3      <= pin_s2;
      pin_lvl_reg <= pin_lvl_next;
    end
  end

  logic start_lvl;                    // Filtered start level
  logic tester_run;                   // Tester reset released
  logic test_mode;                    // Filtered test mode
  assign start_lvl  = pin_lvl_reg[0];
  assign tester_run = pin_lvl_reg[1];
  assign test_mode  = pin_lvl_reg[2];

  // ----------------------------------------------------------------
  // Instruction ROM
  // ----------------------------------------------------------------
  // Only the observed entries carry codes; other steps are plain
  function automatic cso_byte_t rom_word(input cso_byte_t addr);
    case (addr)
      8'h66, 8'h6C: rom_word = 8'hD0;
      8'h47:        rom_word = 8'hD1;
      8'h11:        rom_word = 8'hD2;
      8'h2E:        rom_word = 8'hD3;
      8'h38:        rom_word = 8'hD4;
      8'h03:        rom_word = 8'hD5;
      8'h22:        rom_word = 8'hD6;
      8'h56:        rom_word = 8'hD7;
      8'h01:        rom_word = 8'hD8;
      8'h3B:        rom_word = 8'hD9;
      8'h65, 8'h6B: rom_word = `CSO_CODE_RESULT;
      `CSO_LAST_PTR: rom_word = `CSO_CODE_FINAL;
      default:      rom_word = `CSO_CODE_NOP;
    endcase
  endfunction

  // Start command decode, used for triggering and for drive enable
  function automatic logic is_start(input logic [3:0] code);
    is_start = (code == `CSO_CMD_OBS_HOLD) || (code == `CSO_CMD_OBS_LOAD) ||
               (code == `CSO_CMD_QUI_HOLD) || (code == `CSO_CMD_QUI_LOAD);
  endfunction

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  cso_state_t  state_reg,  state_next;   // Phase
  logic [16:0] adc_cnt_reg, adc_cnt_next; // Digitizing count
  logic [3:0]  slot_reg,   slot_next;    // Position in instruction
  cso_byte_t   ptr_reg,    ptr_next;     // Program pointer
  logic [3:0]  eoc_cnt_reg, eoc_cnt_next; // Drain, then end pulse
  logic [11:0] res_reg,    res_next;     // Parallel result
  logic        obs_reg,    obs_next;     // Observation enabled
  logic        reload_reg, reload_next;  // Coefficient reload pulse
  logic        start_d_reg;              // Start level, one cycle late
  logic        trigger;                  // Start pin edge or start command this cycle
  logic        cmd_start;                // Start command accepted
  logic        slot_end;                 // Instruction completes
  logic        adc_last;                 // Final digitizing clock

  localparam logic [16:0] ADC_LAST  = 17'(ADC_CYCLES - 1);
  localparam logic [16:0] ADC_HALF  = 17'(ADC_CYCLES / 2);
  localparam logic [3:0]  SLOT_LAST = 4'(`CSO_SLOT_CYCLES - 1);
  localparam logic [3:0]  LEAD_LAST = 4'(`CSO_FIRST_OBS - 1);
  // Final frame needs a full slot; the pulse fills its second half
  localparam logic [3:0]  EOC_LAST  = 4'(`CSO_SLOT_CYCLES - 1);
  localparam logic [3:0]  EOC_HIGH  = 4'(`CSO_SLOT_CYCLES - `CSO_EOC_CYCLES);

  assign cmd_start = cmd_valid && test_mode && is_start(cmd_code);
  assign trigger   = (start_lvl && !start_d_reg) || cmd_start;
  assign slot_end  = (state_reg == CSO_DSP) && (slot_reg == SLOT_LAST);
  assign adc_last  = (state_reg == CSO_ADC) && (adc_cnt_reg == ADC_LAST);

  // Phase sequencing; starts are ignored while a conversion runs
  always_comb begin
    state_next   = state_reg;
    adc_cnt_next = adc_cnt_reg;
    slot_next    = slot_reg;
    ptr_next     = ptr_reg;
    eoc_cnt_next = eoc_cnt_reg;
    res_next     = res_reg;
    obs_next     = obs_reg && tester_run;   // Reset returns the port
    reload_next  = 1'b0;
    case (state_reg)
      CSO_IDLE: begin
        if (trigger) begin
          state_next   = CSO_ADC;
          adc_cnt_next = 17'd0;
          if (cmd_start) begin
            // Bit 2 of the code silences the lines, bit 1 reloads
            obs_next    = !cmd_code[2];
            reload_next = cmd_code[1];
          end
        end
      end
      CSO_ADC: begin
        adc_cnt_next = adc_cnt_reg + 17'd1;
        if (adc_last) begin
          state_next = CSO_LEAD;
          slot_next  = 4'd0;
          ptr_next   = 8'h00;
        end
      end
      CSO_LEAD: begin
        // Offsets the first completed instruction by nine clocks
        slot_next = slot_reg + 4'd1;
        if (slot_reg == LEAD_LAST) begin
          state_next = CSO_DSP;
          slot_next  = 4'd0;
        end
      end
      CSO_DSP: begin
        slot_next = slot_reg + 4'd1;
        if (slot_end) begin
          if (rom_word(ptr_reg) == `CSO_CODE_RESULT) begin
            res_next = scratch_in[15:4];
          end
          if (ptr_reg == `CSO_LAST_PTR) begin
            state_next   = CSO_EOC;
            eoc_cnt_next = 4'd0;
          end else begin
            ptr_next = ptr_reg + 8'd1;
          end
        end
      end
      CSO_EOC: begin
        // Quiet drain first, so a repeat start never meets a live frame
        eoc_cnt_next = eoc_cnt_reg + 4'd1;
        if (eoc_cnt_reg == EOC_LAST) begin
          if (cfg_word[`CSO_CFG_REPEAT]) begin
            state_next   = CSO_ADC;
            adc_cnt_next = 17'd0;
          end else begin
            state_next = CSO_IDLE;
          end
        end
      end
      default: begin
        state_next = CSO_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg   <= CSO_IDLE;
      adc_cnt_reg <= 17'd0;
      slot_reg    <= 4'd0;
      ptr_reg     <= 8'h00;
      eoc_cnt_reg <= 4'd0;
      res_reg     <= 12'h000;
      obs_reg     <= 1'b0;
      reload_reg  <= 1'b0;
      start_d_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      adc_cnt_reg <= adc_cnt_next;
      slot_reg    <= slot_next;
      ptr_reg     <= ptr_next;
      eoc_cnt_reg <= eoc_cnt_next;
      res_reg     <= res_next;
      obs_reg     <= obs_next;
      reload_reg  <= reload_next;
      start_d_reg <= start_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Observation lines
  // ----------------------------------------------------------------
  logic obs_data;                     // Scratch serial bit
  logic obs_stat;                     // Pointer/store serial bit
  logic obs_busy;                     // Frame in flight

  cso_obs_shifter u_shift (
    .clock         (clock),
    .rst           (rst),
    .load          (slot_end),
    .scratch       (scratch_in),
    .pointer       (ptr_reg),
    .program_store (rom_word(ptr_reg)),
    .data_bit      (obs_data),
    .status_bit    (obs_stat),
    .busy          (obs_busy)
  );

  // Status line is released at once while the tester holds reset
  assign sdio_oe            = obs_reg && tester_run;
  assign serial_observe_oe  = obs_reg;
  assign sdio_out           = obs_stat;
  assign serial_observe_out = obs_data;

  // ----------------------------------------------------------------
  // Outputs and analog support
  // ----------------------------------------------------------------
  // Temperature uses the first half; at 125 MHz the warm-up window is
  // shorter than with a slow resonator, it scales with the clock.
  assign adc_temp_phase  = (state_reg == CSO_ADC) && (adc_cnt_reg < ADC_HALF);
  assign adc_busy        = (state_reg == CSO_ADC);
  assign program_pointer = ptr_reg;
  assign program_store   = rom_word(ptr_reg);
  assign coef_reload     = reload_reg;
  assign result          = res_reg;
  assign eoc             = (state_reg == CSO_EOC) &&
                           (eoc_cnt_reg >= EOC_HIGH);
  assign amp_enable      = cfg_word[`CSO_CFG_AMP_ON];

  // First-order modulator: carry density tracks the result
  logic [11:0] dac_acc_reg, dac_acc_next;
  logic        dac_bit_reg, dac_bit_next;
  always_comb begin
    {dac_bit_next, dac_acc_next} = {1'b0, dac_acc_reg} + {1'b0, res_reg};
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      dac_acc_reg <= 12'h000;
      dac_bit_reg <= 1'b0;
    end else begin
      dac_acc_reg <= dac_acc_next;
      dac_bit_reg <= dac_bit_next;
    end
  end
  assign dac_out = dac_bit_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  eoc_width_a: assert property (@(posedge clock) disable iff (rst)
    $rose(eoc) |-> eoc [*8] ##1 !eoc)
    else $error("end pulse is not eight clocks");

  eoc_after_dsp_a: assert property (@(posedge clock) disable iff (rst)
    $rose(eoc) |-> $past(state_reg == CSO_DSP && ptr_reg == `CSO_LAST_PTR, 9))
    else $error("end pulse without finished microcode");

  adc_to_dsp_a: assert property (@(posedge clock) disable iff (rst)
    adc_last |=> state_reg == CSO_LEAD ##9 state_reg == CSO_DSP)
    else $error("digitizing phase did not hand over");

  ptr_step_a: assert property (@(posedge clock) disable iff (rst)
    (slot_end && ptr_reg != `CSO_LAST_PTR) |=>
      ##15 (slot_end && ptr_reg == $past(ptr_reg, 16) + 8'd1))
    else $error("instruction cadence is not sixteen clocks");

  store_steady_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == CSO_DSP && !slot_end) |=> $stable(program_store))
    else $error("program store changed mid instruction");

  status_release_a: assert property (@(posedge clock) disable iff (rst)
    !tester_run |-> !sdio_oe)
    else $error("status line driven during tester reset");

  quiet_outside_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == CSO_ADC && adc_cnt_reg > 17'd1) |-> !obs_busy)
    else $error("frame outside microcode phase");

  repeat_restart_a: assert property (@(posedge clock) disable iff (rst)
    (eoc && eoc_cnt_reg == EOC_LAST && cfg_word[`CSO_CFG_REPEAT]) |=>
      state_reg == CSO_ADC && adc_cnt_reg == 17'd0)
    else $error("repeat mode did not restart");

  quiet_cmd_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == CSO_IDLE && cmd_start && cmd_code[2]) |=> !serial_observe_oe)
    else $error("silent start enabled the lines");

endmodule

// File: verif/cso_tester_model.sv
// Tester and host stand-in on the far side of the sequencer pins.
// Assumes the bench clock; both lines are latched on its falling edge.
`timescale 1ns/10ps

module cso_tester_model (
  input  wire logic        clock,
  input  wire logic        clear,
  input  wire logic        drive_en,
  input  wire logic        sdio_out,
  input  wire logic        sdio_oe,
  input  wire logic        serial_observe_out,
  input  wire logic        serial_observe_oe,
  input  wire logic        eoc,
  input  wire logic [11:0] result,
  output logic             sdio_in,
  output logic [15:0]      ea_word,
  output logic [11:0]      latched,
  output int               final_cnt,
  output int               clash_cnt
);
  logic [15:0] stat_sh = 16'h0000; // Status line history
  logic [15:0] data_sh = 16'h0000; // Data line history
  logic        eoc_d   = 1'b0;     // End pulse at last fall
  logic        dead    = 1'b0;     // Flips on undriven wires
  logic        sdo_w;              // Data pin level

  // ----------------------------------------------------------------
  // Pin levels and capture
  // ----------------------------------------------------------------
  // A released pin keeps moving, so a stale bit never passes
  assign sdio_in = sdio_oe ? sdio_out : (drive_en ? 1'b1 : dead);
  assign sdo_w   = serial_observe_oe ? serial_observe_out : ~dead;

  // Falling-edge sampling, as a tester latches both lines
  always @(negedge clock) begin
    stat_sh = {stat_sh[14:0], sdio_in};
    data_sh = {data_sh[14:0], sdo_w};
    dead    = ~dead;
    // Both parties driving the status pin at once
    if (sdio_oe === 1'b1 && drive_en === 1'b1)
      clash_cnt++;
    // Keep the data word shown beside the result step
    if (stat_sh === 16'hEA65 || stat_sh === 16'hEA6B)
      ea_word = data_sh;
    if (stat_sh === 16'hD0C9)
      final_cnt++;
    // Host takes the result as the end pulse falls
    if (eoc_d === 1'b1 && eoc === 1'b0)
      latched = result;
    eoc_d = eoc;
    if (clear) begin
      ea_word   = 16'h0000;
      final_cnt = 0;
    end
  end
endmodule

// File: verif/tb_conversion_sequencer_observe_port.sv
// Self-checking bench for the conversion sequencer and observe port.
// Assumes rtl files compiled first; the digitizing phase is shortened.
`timescale 1ns/10ps

module tb_conversion_sequencer_observe_port;
  import cso_pkg::*;

  localparam int ADC = 40; // Short digitizing phase keeps runs brief

  // Row: code, test pin, starts, observes, reloads
  typedef struct packed {
    logic [3:0] code;
    logic       tm;
    logic       go;
    logic       obs;
    logic       rel;
  } cso_row_t;

  localparam cso_row_t ROWS [6] = '{
    '{4'h8, 1'b1, 1'b1, 1'b1, 1'b0}, '{4'hA, 1'b1, 1'b1, 1'b1, 1'b1},
    '{4'hC, 1'b1, 1'b1, 1'b0, 1'b0}, '{4'hE, 1'b1, 1'b1, 1'b0, 1'b1},
    '{4'h9, 1'b1, 1'b0, 1'b0, 1'b0}, '{4'h8, 1'b0, 1'b0, 1'b0, 1'b0}};

  logic        clock = 1'b0, rst = 1'b1, start_pin = 1'b0;
  logic        tester_reset_n_pin = 1'b1, test_mode_pin = 1'b1;
  logic        cmd_valid = 1'b0, clear = 1'b0, drive_en = 1'b1;
  logic [3:0]  cmd_code = 4'h0;
  cso_word_t   cfg_word = 16'h0000, scratch_in = 16'h0000;
  logic        sdio_in, sdio_out, sdio_oe, serial_observe_out;
  logic        serial_observe_oe, coef_reload, adc_temp_phase;
  logic        adc_busy, eoc, dac_out, amp_enable;
  cso_byte_t   program_pointer, program_store;
  logic [11:0] result, latched;
  logic [15:0] ea_word;
  logic [1:0]  oe_seen;
  int          final_cnt, clash_cnt, err_count, comparisons;
  int          n_adc, n_temp, n_dsp, n_eoc, n_rel, n_bad;

  always #4 clock = ~clock;

  // Datapath stand-in: each step's scratch carries its pointer
  always @(posedge clock)
    scratch_in <= {8'hA5, program_pointer};

  cso_sequencer #(.ADC_CYCLES(ADC)) dut (
    .clock(clock), .rst(rst), .start_pin(start_pin),
    .tester_reset_n_pin(tester_reset_n_pin), .test_mode_pin(test_mode_pin),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cfg_word(cfg_word),
    .scratch_in(scratch_in), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_observe_out(serial_observe_out),
    .serial_observe_oe(serial_observe_oe),
    .program_pointer(program_pointer), .program_store(program_store),
    .coef_reload(coef_reload), .adc_temp_phase(adc_temp_phase),
    .adc_busy(adc_busy), .result(result), .eoc(eoc), .dac_out(dac_out),
    .amp_enable(amp_enable));

  cso_tester_model tester (
    .clock(clock), .clear(clear), .drive_en(drive_en),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_observe_out(serial_observe_out),
    .serial_observe_oe(serial_observe_oe), .eoc(eoc), .result(result),
    .sdio_in(sdio_in), .ea_word(ea_word), .latched(latched),
    .final_cnt(final_cnt), .clash_cnt(clash_cnt));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Tester releases the status pin once its command is in
  task automatic issue(input logic [3:0] code);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    clear     <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    clear     <= 1'b0;
    drive_en  <= 1'b0;
  endtask

  // Low pulse on the tester reset before driving the pin again
  task automatic tester_reset();
    @(posedge clock);
    tester_reset_n_pin <= 1'b0;
    repeat (16) @(posedge clock);
    tester_reset_n_pin <= 1'b1;
    drive_en           <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  // Follow one conversion to the fall of its end pulse
  task automatic run_conv();
    n_adc = 0;
    n_temp = 0;
    n_dsp = 0;
    n_eoc = 0;
    n_rel = 0;
    n_bad = 0;
    for (int t = 0; t < 5000; t++) begin
      @(negedge clock);
      if (n_eoc > 0 && eoc !== 1'b1)
        return;
      n_rel += int'(coef_reload === 1'b1);
      if (eoc === 1'b1)
        n_eoc++;
      else if (adc_busy === 1'b1) begin
        n_adc++;
        n_temp += int'(adc_temp_phase === 1'b1);
        if (n_adc == 1)
          oe_seen = {sdio_oe, serial_observe_oe};
        // Lines must be quiet late in the digitizing phase
        if (n_adc > 20 && {sdio_out, serial_observe_out} !== 2'b00)
          n_bad++;
      end else if (n_adc > 0)
        n_dsp++;
    end
    err_count++;
    $display("wrong value at %0t: conversion did not end", $time);
    test_done();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clock);
    check(16'({sdio_oe, serial_observe_oe, eoc, dac_out}), 16'h0000);
    check(16'(result), 16'h0000);
    check({program_store, program_pointer}, 16'h0000);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // Command table: starts, silences and refusals
    foreach (ROWS[i]) begin
      @(posedge clock);
      test_mode_pin <= ROWS[i].tm;
      tester_reset();
      issue(ROWS[i].code);
      if (ROWS[i].go) begin
        run_conv();
        check(16'(n_adc), 16'(ADC));
        check(16'(n_eoc), 16'h0008);
        check(16'(n_dsp >= 3220 && n_dsp <= 3364), 16'h0001);
        check(16'(n_temp > 0 && 2 * n_temp <= ADC), 16'h0001);
        check(16'(n_rel), 16'(ROWS[i].rel));
        check(16'(oe_seen), 16'({2{ROWS[i].obs}}));
        check(16'(n_bad + int'(adc_busy !== 1'b0)), 16'h0000);
        repeat (12) @(negedge clock);
        check(16'(final_cnt), 16'(ROWS[i].obs));
        check(16'(ea_word[15:4]), ROWS[i].obs ? 16'h0A56 : 16'h0000);
        check(16'(latched), 16'h0A56);
      end else begin
        repeat (12) @(negedge clock);
        check(16'(adc_busy), 16'h0000);
      end
    end
    // Tester reset in mid-conversion drops the observation lines
    @(posedge clock);
    test_mode_pin <= 1'b1;
    tester_reset();
    issue(4'hA);
    tester_reset();
    check(16'({sdio_oe, serial_observe_oe}), 16'h0000);
    run_conv();
    check(16'(n_eoc), 16'h0008);
    repeat (12) @(negedge clock);
    check(16'(final_cnt), 16'h0000);
    // Start held high through a reset, with repeat mode set
    @(posedge clock);
    cfg_word  <= 16'h8080;
    start_pin <= 1'b1;
    rst       <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    run_conv();
    check(16'(n_adc), 16'(ADC));
    check(16'({amp_enable, adc_busy}), 16'h0003);
    @(posedge clock);
    cfg_word <= 16'h0000;
    run_conv();
    check(16'({amp_enable, adc_busy}), 16'h0000);
    check(16'(latched), 16'h0A56);
    // Host lowers start after taking the result, then raises it
    @(posedge clock);
    start_pin <= 1'b0;
    repeat (3) @(posedge clock);
    start_pin <= 1'b1;
    run_conv();
    check(16'(n_adc), 16'(ADC));
    check(16'(clash_cnt), 16'h0000);
    // Bit density over one full accumulator turn equals the result
    n_bad = 0;
    repeat (4096) begin
      @(negedge clock);
      n_bad += int'(dac_out === 1'b1);
    end
    check(16'(n_bad), 16'h0A56);
    test_done();
  end
endmodule
